// [design/dps_pkg.sv]
package dps_pkg;

   // ----------------------------------------------------------------
   // Command word layout
   // ----------------------------------------------------------------
   localparam int CA_BYTES = 6;
   localparam int CA_W = 48;
   localparam int CA_DIR_BIT = 47;
   localparam int CA_SPACE_BIT = 46;
   localparam int CA_BURST_BIT = 45;
   localparam int CA_ROW_HI = 44;
   localparam int CA_ROW_LO = 16;
   localparam int CA_COL_HI = 2;
   localparam int CA_COL_LO = 0;

   // ----------------------------------------------------------------
   // Widths and reset values
   // ----------------------------------------------------------------
   localparam int ADDR_W = 32;
   localparam int WORD_W = 16;
   localparam int LAT_W = 4;
   localparam int HALF_PAGE_WORDS = 8;
   localparam logic [7:0] DQ_RST = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RST = 32'h00000000;
   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
   localparam logic [2:0] CNT_RST = 3'h0;
   localparam logic [LAT_W:0] LAT_RST = 5'h00;

   typedef enum logic [2:0] {
      DPS_IDLE,
      DPS_CMD,
      DPS_LAT,
      DPS_READ,
      DPS_WRITE,
      DPS_DONE
   } dps_state_e;

endpackage

// [design/dps_front_end.sv]
// What this block does
// - Each chip select low period is exactly one transaction.
// - Bus clock may stop between transactions; single or differential.
// - Six command bytes on the first six clock edges, high byte first.
// - Command bytes are sampled at the clock transitions.
// - Byte bit 7 travels on data line 7, bit 0 on line 0.
// - Command bit 47 high means read, low means write.
// - Command bit 46 low selects memory, high selects register space.
// - Command bit 45 low selects wrapped burst, high linear burst.
// - Command bits 44..16 carry word address bits 31..3.
// - Command bits 15..3 are reserved and ignored.
// - Command bits 2..0 carry word address bits 2..0.
// - Upper column picks an eight word half-page, lower the word.
// - Read access starts once all six command bytes are in; bursts run on.
// - Strobe shows extra latency need during the command phase.
// - During reads the strobe is driven with edge aligned data.
// - During writes the host drives the strobe as byte mask.
// - Hardware reset floats strobe and data lines and idles the block.
// - Whole 16-bit words move; address steps once per word.
// - Read byte A while strobe high, byte B while strobe low.
// - Device may pause a read burst with strobe held low.
// - Strobe high in command phase doubles the latency count.
// - Write bytes masked high are kept, masked low are written.
// - Write byte A on clock rise, byte B on clock fall.
`timescale 1ns/100ps
`default_nettype none

module dps_front_end
   import dps_pkg::*;
#(
   parameter bit DIFF_CLK = 1'b0,
   parameter int WRAP_WORDS = dps_pkg::HALF_PAGE_WORDS
)
(
   // System clock and reset.
   input wire logic ref_clk,
   input wire logic reset_n,
   // Bus pins.
   input wire logic cs_n,
   input wire logic bus_clk_true,
   input wire logic bus_clk_comp,
   input wire logic hw_reset_n,
   input wire logic [7:0] dq_in,
   output logic [7:0] dq_out,
   output logic dq_oe_n,
   input wire logic strobe_in,
   output logic strobe_out,
   output logic strobe_oe_n,
   // Latency control from the array side.
   input wire logic [dps_pkg::LAT_W-1:0] init_latency,
   input wire logic refresh_need,
   input wire logic row_pause,
   // Transaction status.
   output logic txn_active,
   output logic txn_read,
   output logic txn_reg_space,
   output logic txn_linear,
   // Array access port.
   output logic [dps_pkg::ADDR_W-1:0] mem_addr,
   output logic mem_rd,
   input wire logic [dps_pkg::WORD_W-1:0] mem_rdata,
   output logic mem_wr,
   output logic [dps_pkg::WORD_W-1:0] mem_wdata,
   output logic [1:0] mem_wmask
);
   import dps_pkg::*;

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (WRAP_WORDS < 2 || (WRAP_WORDS & (WRAP_WORDS - 1)) != 0)
   begin : g_bad_wrap
      $error("WRAP_WORDS must be a power of two of at least 2");
   end

   // Step a word address; wrapped bursts stay inside their group.
   function automatic logic [ADDR_W-1:0] next_addr(
      input logic [ADDR_W-1:0] a,
      input logic linear
   );
      logic [ADDR_W-1:0] m;
      logic [ADDR_W-1:0] inc;
      m = ADDR_W'(WRAP_WORDS - 1);
      inc = a + 32'h00000001;
      if (linear)
         next_addr = inc;
      else
         next_addr = (a & ~m) | (inc & m);
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic cs_s1, cs_s2, ckt_s1, ckt_s2, ckc_s1, ckc_s2;
   logic hwr_s1, hwr_s2, rw_s1, rw_s2, clk_lvl, clk_d;
   logic [7:0] dq_s1, dq_s2;

   // Every pin passes two flops; data and clock see equal delay, so a
   // centre aligned byte is still stable when its clock edge is seen.
   // The chain has no reset; the pins flush it while reset is held.
   always_ff @(posedge ref_clk)
   begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      ckt_s1 <= bus_clk_true;
      ckt_s2 <= ckt_s1;
      ckc_s1 <= bus_clk_comp;
      ckc_s2 <= ckc_s1;
      hwr_s1 <= hw_reset_n;
      hwr_s2 <= hwr_s1;
      rw_s1 <= strobe_in;
      rw_s2 <= rw_s1;
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      clk_d <= clk_lvl;
   end

   // ----------------------------------------------------------------
   // Bus clock edge detection
   // ----------------------------------------------------------------
   logic rise, fall, rst;

   // The bus clock is only sampled, never used as a clock, so a stopped
   // clock simply yields no edges.
   assign clk_lvl = DIFF_CLK ? (ckt_s2 & ~ckc_s2) : ckt_s2;
   assign rise = clk_lvl & ~clk_d & ~cs_s2;
   assign fall = ~clk_lvl & clk_d & ~cs_s2;
   assign rst = ~reset_n | ~hwr_s2;

   // ----------------------------------------------------------------
   // Transaction sequencing
   // ----------------------------------------------------------------
   dps_state_e state;
   logic [CA_W-9:0] ca;
   logic [CA_W-1:0] ca_full;
   logic [2:0] ca_cnt;
   logic [LAT_W:0] lat_cnt, lat_total;
   logic extra, lat_done, data_rise, word_live;
   logic [LAT_W-1:0] lat_one;

   assign ca_full = {ca, dq_s2};
   // A zero latency setting is served as one cycle.
   assign lat_one = (init_latency == '0) ? 4'h1 : init_latency;
   assign lat_total = extra ? {lat_one, 1'b0} : {1'b0, lat_one};
   assign lat_done = (state == DPS_LAT) && (lat_cnt == lat_total);
   assign data_rise = rise && (lat_done || state == DPS_READ ||
                               state == DPS_WRITE);

   // One chip select low period is one transaction; a high chip select
   // always returns to idle so capture restarts at the first byte.
   always_ff @(posedge ref_clk)
   begin
      if (rst || cs_s2)
         state <= DPS_IDLE;
      else
      begin
         case (state)
            DPS_IDLE:
               state <= DPS_CMD;
            DPS_CMD:
               if ((rise || fall) && ca_cnt == 3'(CA_BYTES - 1))
                  state <= DPS_LAT;
            DPS_LAT:
               if (data_rise)
                  state <= txn_read ? DPS_READ : DPS_WRITE;
            DPS_READ, DPS_WRITE, DPS_DONE:
               state <= state;
            default:
               state <= DPS_IDLE;
         endcase
      end
   end

   // Command bytes shift in on both clock edges.
   always_ff @(posedge ref_clk)
   begin
      if (rst || state == DPS_IDLE)
      begin
         ca <= '0;
         ca_cnt <= CNT_RST;
      end
      else if (state == DPS_CMD && (rise || fall))
      begin
         ca <= ca_full[CA_W-9:0];
         ca_cnt <= ca_cnt + 3'h1;
      end
   end

   // Latency request is frozen when the transaction opens.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         extra <= 1'b0;
      else if (state == DPS_IDLE)
         extra <= refresh_need;
   end

   // Latency counts whole bus clock cycles after the command phase.
   always_ff @(posedge ref_clk)
   begin
      if (rst || state != DPS_LAT)
         lat_cnt <= LAT_RST;
      else if (rise && !lat_done)
         lat_cnt <= lat_cnt + 5'h01;
   end

   // ----------------------------------------------------------------
   // Decode and address tracking
   // ----------------------------------------------------------------
   logic ca_last;
   assign ca_last = state == DPS_CMD && (rise || fall) &&
                    ca_cnt == 3'(CA_BYTES - 1);

   // Reserved bits 15..3 are simply not looked at.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         txn_read <= 1'b0;
         txn_reg_space <= 1'b0;
         txn_linear <= 1'b0;
         mem_addr <= ADDR_RST;
      end
      else if (ca_last)
      begin
         txn_read <= ca_full[CA_DIR_BIT];
         txn_reg_space <= ca_full[CA_SPACE_BIT];
         txn_linear <= ca_full[CA_BURST_BIT];
         mem_addr <= {ca_full[CA_ROW_HI:CA_ROW_LO],
                      ca_full[CA_COL_HI:CA_COL_LO]};
      end
      // Step as each word leaves, so the next fetch sees its address.
      else if (mem_wr || (data_rise && txn_read && !row_pause))
         mem_addr <= next_addr(mem_addr, txn_linear);
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         txn_active <= 1'b0;
      else
         txn_active <= state != DPS_IDLE;
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic rd_valid, rd_first, rd_next;
   logic [WORD_W-1:0] rd_word;
   logic [7:0] byte_b;

   // The first fetch goes out as soon as the command is complete, long
   // before the first data edge; later fetches follow each word out.
   // The address steps as a word leaves, so the fetch raised a cycle
   // later already reads the next word.
   assign rd_first = ca_last && ca_full[CA_DIR_BIT];
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         mem_rd <= 1'b0;
         rd_next <= 1'b0;
         rd_valid <= 1'b0;
         rd_word <= WORD_RST;
      end
      else
      begin
         rd_next <= data_rise && txn_read && !row_pause;
         mem_rd <= rd_first || rd_next;
         rd_valid <= mem_rd;
         if (rd_valid)
            rd_word <= mem_rdata;
      end
   end

   // Byte A leaves with the strobe rise, byte B with its fall. A paused
   // cycle keeps the strobe low and sends nothing.
   always_ff @(posedge ref_clk)
   begin
      if (rst || cs_s2)
      begin
         dq_out <= DQ_RST;
         byte_b <= DQ_RST;
         word_live <= 1'b0;
         strobe_out <= 1'b0;
      end
      else if (state == DPS_CMD || (state == DPS_LAT && !data_rise))
         strobe_out <= extra;
      else if (data_rise && txn_read)
      begin
         word_live <= !row_pause;
         strobe_out <= !row_pause;
         if (!row_pause)
         begin
            dq_out <= rd_word[15:8];
            byte_b <= rd_word[7:0];
         end
      end
      else if (fall && state == DPS_READ && word_live)
      begin
         strobe_out <= 1'b0;
         dq_out <= byte_b;
      end
   end

   // Strobe is ours in the command phase and in reads; in writes it is
   // released after the command so the host can mask. Data lines are
   // driven only in the read data phase.
   always_ff @(posedge ref_clk)
   begin
      if (rst || cs_s2)
      begin
         strobe_oe_n <= 1'b1;
         dq_oe_n <= 1'b1;
      end
      else
      begin
         strobe_oe_n <= !(state == DPS_CMD ||
                          ((state == DPS_LAT || state == DPS_READ) &&
                           txn_read));
         dq_oe_n <= !(state == DPS_READ || (data_rise && txn_read));
      end
   end

   // ----------------------------------------------------------------
   // Write path
   // ----------------------------------------------------------------
   logic [7:0] byte_a;
   logic mask_a;

   // Byte A with its mask arrives on the rise, byte B on the fall; the
   // whole word goes to the array once both are in.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         byte_a <= DQ_RST;
         mask_a <= 1'b1;
         mem_wr <= 1'b0;
         mem_wdata <= WORD_RST;
         mem_wmask <= 2'h3;
      end
      else
      begin
         mem_wr <= 1'b0;
         if (data_rise && !txn_read)
         begin
            byte_a <= dq_s2;
            mask_a <= rw_s2;
         end
         else if (fall && state == DPS_WRITE)
         begin
            mem_wr <= 1'b1;
            mem_wdata <= {byte_a, dq_s2};
            mem_wmask <= {mask_a, rw_s2};
         end
      end
   end

endmodule

`default_nettype wire

// [verif/dps_front_end_props.sv]
`timescale 1ns/100ps
`default_nettype none

module dps_front_end_props
(
   // Clock and resets.
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic hw_reset_n,
   // Bus pins.
   input wire logic cs_n,
   input wire logic dq_oe_n,
   input wire logic strobe_oe_n,
   // Status and array side.
   input wire logic txn_active,
   input wire logic txn_read,
   input wire logic txn_linear,
   input wire logic [dps_pkg::ADDR_W-1:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr
);
   // ----------------------------------------------------------------
   // Timing frame
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   // Both windows leave room for the two flop synchronisers.
   sequence s_hw_low;
      (!hw_reset_n) [*5];
   endsequence
   sequence s_deselected;
      cs_n [*6];
   endsequence

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_hw_float;
      s_hw_low |-> dq_oe_n && strobe_oe_n;
   endproperty
   a_hw_float: assert property (p_hw_float)
      else $error("pins driven during bus reset");
   property p_idle;
      s_deselected |-> dq_oe_n && strobe_oe_n && !txn_active;
   endproperty
   a_idle: assert property (p_idle)
      else $error("bus active while deselected");
   property p_wr_pulse;
      mem_wr |-> !mem_rd ##1 !mem_wr;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("write pulse too long");
   property p_rd_pulse;
      mem_rd |=> !mem_rd;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read pulse too long");
   property p_wr_dir;
      mem_wr |-> txn_active && !txn_read && strobe_oe_n;
   endproperty
   a_wr_dir: assert property (p_wr_dir)
      else $error("array write outside a write");
   property p_rd_dir;
      mem_rd |-> txn_active && txn_read;
   endproperty
   a_rd_dir: assert property (p_rd_dir)
      else $error("array read outside a read");
   property p_dq_read;
      !dq_oe_n |-> txn_read || $past(txn_read);
   endproperty
   a_dq_read: assert property (p_dq_read)
      else $error("data driven outside a read");
   property p_dq_strobe;
      !dq_oe_n |-> !strobe_oe_n;
   endproperty
   a_dq_strobe: assert property (p_dq_strobe)
      else $error("data driven without strobe");
   property p_lin_step;
      mem_wr && txn_linear |-> ##3 mem_addr == $past(mem_addr, 3) + 32'h1;
   endproperty
   a_lin_step: assert property (p_lin_step)
      else $error("address did not step");
endmodule

`default_nettype wire

// [verif/dps_host_model.sv]
`timescale 1ns/100ps
`default_nettype none

module dps_host_model
(
   // System clock paces the host.
   input wire logic ref_clk,
   // Bus pins driven by the host.
   output logic cs_n,
   output logic clk_t,
   output logic clk_c,
   output logic [7:0] dq,
   output logic strobe
);
   // Bus idles deselected with the clock stopped low.
   initial
   begin
      cs_n = 1'b1;
      clk_t = 1'b0;
      clk_c = 1'b1;
      dq = 8'h00;
      strobe = 1'b1;
   end

   // One half period of 80 ns; data sits centred on the edge.
   task automatic half(input logic [7:0] d, input logic m);
   begin
      dq <= d;
      strobe <= m;
      repeat (5) @(posedge ref_clk);
      clk_t <= ~clk_t;
      clk_c <= clk_t;
      repeat (5) @(posedge ref_clk);
   end
   endtask

   // Select falls with the clock idle, then six bytes high first.
   task automatic open_txn(input logic [47:0] ca);
   begin
      @(posedge ref_clk);
      cs_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      for (int i = 5; i >= 0; i--)
         half(ca[i*8 +: 8], 1'b0);
   end
   endtask

   // Released data lines show the inverse so stale data cannot pass.
   task automatic close_txn;
   begin
      repeat (5) @(posedge ref_clk);
      dq <= ~dq;
      cs_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
   end
   endtask
endmodule

`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/100ps
`default_nettype none

module tb;
   import dps_pkg::*;
   localparam int LAT = 2;
   logic ref_clk, reset_n, hw_reset_n, refresh_need, row_pause;
   logic [3:0] init_latency;
   logic [15:0] mem_rdata, mem_wdata;
   logic [7:0] dq_out;
   logic dq_oe_n, strobe_out, strobe_oe_n, mem_rd, mem_wr;
   logic txn_active, txn_read, txn_reg_space, txn_linear;
   logic [31:0] mem_addr;
   logic [1:0] mem_wmask;
   logic [49:0] wq[$];
   int mismatches, checks;
   wire logic cs_n, ck_t, ck_c, h_st;
   wire logic [7:0] h_dq;
   // Pin levels resolved from the device's output enables; the host always drives.
   wire logic [7:0] dq_pin = dq_oe_n ? h_dq : dq_out;
   wire logic st_pin = strobe_oe_n ? h_st : strobe_out;

   dps_host_model hm (.ref_clk(ref_clk), .cs_n(cs_n), .clk_t(ck_t),
      .clk_c(ck_c), .dq(h_dq), .strobe(h_st));
   dps_front_end #(.DIFF_CLK(1'b1)) dut (.ref_clk(ref_clk),
      .reset_n(reset_n), .cs_n(cs_n), .bus_clk_true(ck_t),
      .bus_clk_comp(ck_c), .hw_reset_n(hw_reset_n), .dq_in(dq_pin),
      .dq_out(dq_out), .dq_oe_n(dq_oe_n), .strobe_in(st_pin),
      .strobe_out(strobe_out), .strobe_oe_n(strobe_oe_n),
      .init_latency(init_latency), .refresh_need(refresh_need),
      .row_pause(row_pause), .txn_active(txn_active),
      .txn_read(txn_read), .txn_reg_space(txn_reg_space),
      .txn_linear(txn_linear), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
      .mem_wmask(mem_wmask));

   // Array model answers reads a cycle later and logs writes.
   always @(posedge ref_clk)
   begin
      if (mem_rd === 1'b1)
         mem_rdata <= {mem_addr[7:0], mem_addr[7:0] ^ 8'hA5};
      if (mem_wr === 1'b1)
         wq.push_back({mem_addr, mem_wdata, mem_wmask});
   end

   task automatic chk(input logic [49:0] got, input logic [49:0] exp);
   begin
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   end
   endtask

   task automatic close_out;
   begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask

   // Read burst; wrapped bursts stay inside the eight word group. A
   // row pause is asked for at the data rise meant for word pz.
   task automatic rd_test(input logic rf, input logic [47:0] ca,
      input int n, input int pz);
      logic [31:0] a, wa;
   begin
      a = {ca[44:16], ca[2:0]};
      refresh_need <= rf;
      hm.open_txn(ca);
      chk({strobe_oe_n, strobe_out}, {1'b0, rf});
      chk({txn_read, txn_reg_space, txn_linear}, ca[47:45]);
      chk(mem_addr, a);
      repeat (rf ? 4 * LAT : 2 * LAT) hm.half(8'h3C, 1'b0);
      for (int w = 0; w < n; w++)
      begin
         wa = ca[45] ? a + w : {a[31:3], 3'(a[2:0] + w)};
         if (w == pz)
         begin
            row_pause <= 1'b1;
            hm.half(8'hC3, 1'b0);
            chk({strobe_out, dq_oe_n}, 2'b00);
            row_pause <= 1'b0;
            hm.half(8'h3C, 1'b0);
         end
         hm.half(8'hC3, 1'b0);
         chk({strobe_out, dq_oe_n, dq_out}, {2'b10, wa[7:0]});
         hm.half(8'h3C, 1'b0);
         chk({strobe_out, dq_out}, {1'b0, wa[7:0] ^ 8'hA5});
      end
      hm.close_txn();
      chk({dq_oe_n, strobe_oe_n}, 2'b11);
      $display("read test done");
   end
   endtask

   // Masked linear write crossing a half-page.
   task automatic wr_test;
   begin
      wq.delete();
      refresh_need <= 1'b0;
      hm.open_txn({3'b001, 29'h123, 13'h0, 3'h7});
      chk({strobe_oe_n, txn_read, txn_linear}, 3'b101);
      repeat (2 * LAT) hm.half(8'h00, 1'b0);
      hm.half(8'h12, 1'b1);
      hm.half(8'h34, 1'b0);
      hm.half(8'h56, 1'b0);
      hm.half(8'h78, 1'b1);
      hm.close_txn();
      chk(wq.size(), 2);
      chk(wq[0], {32'h91F, 16'h1234, 2'b10});
      chk(wq[1], {32'h920, 16'h5678, 2'b01});
      $display("write test done");
   end
   endtask

   // Stray clocks while deselected, then a bus reset mid read.
   task automatic hw_reset_test;
   begin
      hm.half(8'hFF, 1'b1);
      hm.half(8'hFF, 1'b1);
      hm.open_txn({3'b100, 29'h5, 16'h0001});
      hw_reset_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk({dq_oe_n, strobe_oe_n}, 2'b11);
      hw_reset_n <= 1'b1;
      hm.close_txn();
      $display("bus reset test done");
   end
   endtask

   // Free running system clock.
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // Watchdog cuts a hang short.
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      close_out();
   end

   // Main sequence.
   initial
   begin
      reset_n = 1'b0;
      hw_reset_n = 1'b1;
      init_latency = 4'h2;
      refresh_need = 1'b0;
      row_pause = 1'b0;
      mem_rdata = 16'h0000;
      mismatches = 0;
      checks = 0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd_test(1'b0, {3'b101, 29'h42, 13'h1FFF, 3'h6}, 3, -1);
      rd_test(1'b1, {3'b110, 29'h7, 13'h0, 3'h6}, 3, 1);
      wr_test();
      hw_reset_test();
      rd_test(1'b0, {3'b100, 29'h1, 13'h0, 3'h7}, 2, -1);
      close_out();
   end
endmodule

bind dps_front_end dps_front_end_props u_props (.ref_clk(ref_clk),
   .reset_n(reset_n), .hw_reset_n(hw_reset_n), .cs_n(cs_n),
   .dq_oe_n(dq_oe_n), .strobe_oe_n(strobe_oe_n),
   .txn_active(txn_active), .txn_read(txn_read),
   .txn_linear(txn_linear), .mem_addr(mem_addr), .mem_rd(mem_rd),
   .mem_wr(mem_wr));

`default_nettype wire
